// ===== rtl/prio_status.sv
// priority registers and pending vector status behind an APB slave
//
// The APB register port and the address map are this design's own decisions.
`default_nettype none
module prio_status (
	input wire logic clk, // system clock, 100 MHz
	input wire logic reset_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic [3:0] cpu_level_in, // new cpu level from arbitration
	input wire logic [7:0] vector_in, // pending vector number, 8 to 135
	output prio_pkg::levels_type levels_q, // priority fields to arbitration
	output logic irq_q // change interrupt, level
);
	logic [15:0] prio_q [prio_pkg::num_regs];
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pslverr_q, pslverr_d;
	prio_pkg::status_type status_q, status_d;
	logic [1:0] ev_q, ev_d, mask_q;
	prio_pkg::levels_type levels_d;
	logic irq_d;

	wire logic access = psel && penable && !pready_q;
	wire logic wr_en = access && pwrite;
	wire logic [15:0] wdata16 = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
	// byte lanes: an unstrobed lane keeps its old value
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [3:0] strb, input logic [15:0] nw);
		merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction
	// one-hot select over the nine registers; misaligned and unknown addresses select nothing
	function automatic logic [8:0] decode(input logic [11:0] a);
		case (a)
			prio_pkg::pwm3_6_off: decode = 9'h001;
			prio_pkg::pwm7_9_comparator2_priority_off: decode = 9'h002;
			prio_pkg::comparator3_4_priority_off: decode = 9'h004;
			prio_pkg::adc_pair0_1_priority_off: decode = 9'h008;
			prio_pkg::adc_pair2_5_priority_off: decode = 9'h010;
			prio_pkg::adc_pair6_7_priority_off: decode = 9'h020;
			prio_pkg::pending_vector_status_off: decode = 9'h040;
			prio_pkg::irq_status_off: decode = 9'h080;
			prio_pkg::irq_mask_off: decode = 9'h100;
			default: decode = 9'h000;
		endcase
	endfunction
	wire logic [8:0] rd_sel = decode(paddr);
	wire logic [8:0] wr_sel = wr_en ? decode(paddr) : 9'h000;
	wire logic [15:0] rd_term [prio_pkg::num_regs];

	genvar g;
	generate
		for (g = 0; g < prio_pkg::num_regs; g++)
		begin : regs
			wire logic hit = wr_sel[g];
			assign rd_term[g] = rd_sel[g] ? prio_q[g] : 16'h0000;
			prio_reg #(
				.mask(prio_pkg::impl_mask[g]),
				.rst_val(prio_pkg::impl_reset[g])
			) u_reg (
				.clk(clk),
				.reset_n(reset_n),
				.wr(hit),
				.wdata(merge(prio_q[g], pstrb, wdata16)),
				.value_q(prio_q[g])
			);
		end
	endgenerate

	// field extraction; a zero field leaves its source disabled in arbitration
	always_comb
	begin
		levels_d.pwm_ch3_level = prio_q[0][2:0];
		levels_d.pwm_ch7_level = prio_q[1][2:0];
		levels_d.pwm_ch8_level = prio_q[1][6:4];
		levels_d.pwm_ch9_level = prio_q[1][10:8];
		levels_d.comparator2_level = prio_q[1][14:12];
		levels_d.comparator3_level = prio_q[2][2:0];
		levels_d.comparator4_level = prio_q[2][6:4];
		levels_d.adc_pair0_level = prio_q[3][10:8];
		levels_d.adc_pair1_level = prio_q[3][14:12];
		levels_d.adc_pair2_level = prio_q[4][2:0];
		levels_d.adc_pair3_level = prio_q[4][6:4];
		levels_d.adc_pair4_level = prio_q[4][10:8];
		levels_d.adc_pair5_level = prio_q[4][14:12];
		levels_d.adc_pair6_level = prio_q[5][2:0];
		levels_d.adc_pair7_level = prio_q[5][6:4];
	end

	// vector numbers below 8 cannot occur; they are clamped to index 0 rather than wrapping
	wire logic [7:0] vec_rel = (vector_in < 8'(prio_pkg::vector_base)) ? 8'h00 : 8'(vector_in - 8'(prio_pkg::vector_base));
	always_comb
	begin
		status_d.level = cpu_level_in;
		status_d.index = vec_rel[6:0];
	end

	wire logic level_chg = status_d.level != status_q.level;
	wire logic vector_chg = status_d.index != status_q.index;
	wire logic clr_hit = wr_sel[7] && pstrb[0];
	wire logic mask_hit = wr_sel[8] && pstrb[0];
	wire logic [1:0] lvl_ev = level_chg ? prio_pkg::irq_level_chg : 2'h0;
	wire logic [1:0] vec_ev = vector_chg ? prio_pkg::irq_vector_chg : 2'h0;
	wire logic [1:0] ev_set = lvl_ev | vec_ev;
	wire logic [1:0] ev_clr = clr_hit ? pwdata[1:0] : 2'h0;
	// set beats clear so a change in the clearing cycle is kept
	always_comb
	begin
		ev_d = (ev_q & ~ev_clr) | ev_set;
		irq_d = |(ev_d & mask_q);
	end

	// status word is built field by field so the unused bits stay zero
	logic [15:0] status_word;
	always_comb
	begin
		status_word = 16'h0000;
		status_word[prio_pkg::level_lsb +: 4] = status_q.level;
		status_word[prio_pkg::vector_lsb +: 7] = status_q.index;
	end
	wire logic mapped = |rd_sel;
	wire logic [15:0] rd_status = rd_sel[6] ? status_word : 16'h0000;
	wire logic [15:0] rd_events = rd_sel[7] ? {14'h0000, ev_q} : 16'h0000;
	wire logic [15:0] rd_mask = rd_sel[8] ? {14'h0000, mask_q} : 16'h0000;
	// the selects are one-hot, so an or of the gated terms is the read multiplexer
	logic [15:0] rd_word;
	always_comb
	begin
		rd_word = rd_status | rd_events | rd_mask;
		for (int i = 0; i < prio_pkg::num_regs; i++)
			rd_word = rd_word | rd_term[i];
		prdata_d = {16'h0000, rd_word};
		pslverr_d = !mapped;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= access;
			pslverr_q <= access && pslverr_d;
			prdata_q <= (access && !pwrite) ? prdata_d : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			status_q <= '0;
			ev_q <= 2'h0;
			mask_q <= 2'h0;
			irq_q <= 1'b0;
			levels_q <= {prio_pkg::num_fields{prio_pkg::level_reset}};
		end
		else
		begin
			status_q <= status_d;
			ev_q <= ev_d;
			irq_q <= irq_d;
			levels_q <= levels_d;
			if (mask_hit)
				mask_q <= pwdata[1:0];
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule
`default_nettype wire

// ===== inc/prio_pkg.sv
// package: register map, field layout and reset values of the priority and vector status block
`default_nettype none
package prio_pkg;
	localparam logic [11:0] pwm3_6_off = 12'h000;
	localparam logic [11:0] pwm7_9_comparator2_priority_off = 12'h004;
	localparam logic [11:0] comparator3_4_priority_off = 12'h008;
	localparam logic [11:0] adc_pair0_1_priority_off = 12'h00C;
	localparam logic [11:0] adc_pair2_5_priority_off = 12'h010;
	localparam logic [11:0] adc_pair6_7_priority_off = 12'h014;
	localparam logic [11:0] pending_vector_status_off = 12'h018;
	localparam logic [11:0] irq_status_off = 12'h01C;
	localparam logic [11:0] irq_mask_off = 12'h020;
	localparam int num_regs = 6;
	localparam int num_fields = 15;
	localparam logic [2:0] level_reset = 3'h4;
	// writable bits of each priority register, index 0 is pwm3_6
	localparam logic [15:0] impl_mask [num_regs] = '{16'h7777, 16'h7777, 16'h0077, 16'h7700, 16'h7777, 16'h0077};
	localparam logic [15:0] impl_reset [num_regs] = '{16'h4444, 16'h4444, 16'h0044, 16'h4400, 16'h4444, 16'h0044};
	localparam int level_lsb = 8;
	localparam int vector_lsb = 0;
	localparam int vector_base = 8;
	localparam logic [1:0] irq_level_chg = 2'h1;
	localparam logic [1:0] irq_vector_chg = 2'h2;
	typedef struct packed {
		logic [3:0] level;
		logic [6:0] index;
	} status_type;
	typedef struct packed {
		logic [2:0] pwm_ch3_level;
		logic [2:0] pwm_ch7_level;
		logic [2:0] pwm_ch8_level;
		logic [2:0] pwm_ch9_level;
		logic [2:0] comparator2_level;
		logic [2:0] comparator3_level;
		logic [2:0] comparator4_level;
		logic [2:0] adc_pair0_level;
		logic [2:0] adc_pair1_level;
		logic [2:0] adc_pair2_level;
		logic [2:0] adc_pair3_level;
		logic [2:0] adc_pair4_level;
		logic [2:0] adc_pair5_level;
		logic [2:0] adc_pair6_level;
		logic [2:0] adc_pair7_level;
	} levels_type;
endpackage
`default_nettype wire

// ===== rtl/prio_reg.sv
// one 16-bit priority register with fixed implemented-bit mask
`default_nettype none
module prio_reg #(
	parameter logic [15:0] mask = 16'h0000,
	parameter logic [15:0] rst_val = 16'h0000
) (
	input wire logic clk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic wr, // write strobe
	input wire logic [15:0] wdata, // write data
	output logic [15:0] value_q // stored value
);
	wire logic [15:0] value_d = wdata & mask;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			value_q <= rst_val;
		else if (wr)
			value_q <= value_d;
	end
endmodule
`default_nettype wire

// ===== sim/prio_status_sva.sv
// checker for the priority and status block
`default_nettype none
module prio_status_sva (
	input wire logic clk, // clock
	input wire logic reset_n, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] pwdata, // wdata
	input wire logic [3:0] pstrb, // strobes
	input wire logic [31:0] prdata, // rdata
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic [3:0] cpu_level_in, // level
	input wire logic [7:0] vector_in, // vector
	input wire prio_pkg::levels_type levels_q // fields
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	wire logic take = psel && penable && !pready;
	wire logic rd_st = pready && !pwrite && paddr == prio_pkg::pending_vector_status_off;
	wire logic [6:0] vidx = vector_in[6:0] - 7'h08;
	wire logic [2:0] w_c2 = pwdata[14:12];
	wire logic [2:0] w_a7 = pwdata[6:4];
	a_ready_after_take: assert property (take |=> pready) else $error("no ready");
	a_ready_one_pulse: assert property (pready |=> !pready) else $error("long ready");
	a_unmapped_err: assert property (take && paddr > 12'h020 |=> pslverr && prdata == 32'h0000_0000)
		else $error("no error");
	a_upper_read_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000) else $error("upper");
	a_status_level: assert property (rd_st |-> prdata[15:8] == {4'h0, $past(cpu_level_in, 2)}) else $error("lvl");
	a_status_vector: assert property (rd_st |-> prdata[7:0] == {1'b0, $past(vidx, 2)}) else $error("vec");
	a_levels_reset: assert property ($rose(reset_n) |-> levels_q == {15{3'h4}}) else $error("rst");
	a_write_comp2: assert property (take && pwrite && pstrb[1] && paddr == prio_pkg::pwm7_9_comparator2_priority_off
		|-> ##2 levels_q.comparator2_level == $past(w_c2, 2)) else $error("c2");
	a_write_adc7: assert property (take && pwrite && pstrb[0] && paddr == prio_pkg::adc_pair6_7_priority_off
		|-> ##2 levels_q.adc_pair7_level == $past(w_a7, 2)) else $error("a7");
endmodule
bind prio_status prio_status_sva i_prio_status_sva (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .cpu_level_in, .vector_in, .levels_q);
`default_nettype wire

// ===== sim/prio_partner.sv
// arbitration side model: new cpu level and pending vector
`default_nettype none
module prio_partner (
	input wire logic clk, // clock
	input wire logic reset_n, // reset
	input wire logic hold, // freeze
	output logic [3:0] level, // 0 to 15
	output logic [7:0] vector // 8 to 135
);
	timeunit 1ns;
	timeprecision 1ns;
	int seed = 13;
	always @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			level <= 4'h0;
			vector <= 8'h08;
		end
		else if (!hold)
		begin
			level <= 4'($random(seed));
			vector <= 8'h08 + 8'($random(seed) & 127);
		end
endmodule
`default_nettype wire

// ===== sim/prio_status_tb.sv
// testbench for the priority and status block
`default_nettype none
module prio_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, hold = 1, pready, pslverr, irq_q, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, d, rd_s;
	logic [3:0] pstrb = 4'hF, lvl, st;
	logic pready_s = 1'b0, err_s = 1'b0;
	logic [15:0] shadow [prio_pkg::num_regs];
	logic [7:0] vec;
	prio_pkg::levels_type levels_q;
	int bad_count = 0, n_tests = 0, cyc = 0, seed = 13;
	initial forever #5 clk = ~clk;
	prio_status i_prio_status (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .cpu_level_in(lvl), .vector_in(vec), .levels_q, .irq_q);
	prio_partner i_prio_partner (.clk, .reset_n, .hold, .level(lvl), .vector(vec));
	task close_out;
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	// answers are captured mid-cycle, so the rising edge reads what the design settled on
	always @(negedge clk)
	begin
		pready_s <= pready;
		err_s <= pslverr;
		rd_s <= prdata;
	end
	// request held until ready is seen at an edge, released only after it
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready_s !== 1'b1)
			@(posedge clk);
		rd = rd_s;
		err = err_s;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function logic [31:0] stat_exp(input logic [3:0] l, input logic [7:0] v);
		return {20'h0_0000, l, 1'b0, v[6:0] - 7'h08};
	endfunction
	// an unstrobed byte lane keeps its old contents, then unimplemented bits drop out
	function logic [15:0] lane_exp(input logic [15:0] old, input logic [3:0] s, input logic [15:0] v,
		input logic [15:0] m);
		return {s[1] ? v[15:8] : old[15:8], s[0] ? v[7:0] : old[7:0]} & m;
	endfunction
	// field order of the level bundle: pwm3, pwm7, pwm8, pwm9, comparators 2-4, adc pairs 0-7
	function logic [44:0] lv_exp();
		return {shadow[0][2:0], shadow[1][2:0], shadow[1][6:4], shadow[1][10:8], shadow[1][14:12], shadow[2][2:0],
			shadow[2][6:4], shadow[3][10:8], shadow[3][14:12], shadow[4][2:0], shadow[4][6:4], shadow[4][10:8],
			shadow[4][14:12], shadow[5][2:0], shadow[5][6:4]};
	endfunction
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			close_out;
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < prio_pkg::num_regs; i++)
		begin
			apb(1'b0, 12'(4 * i), 32'h0000_0000);
			chk("reset", {16'h0000, prio_pkg::impl_reset[i]}, rd);
			shadow[i] = prio_pkg::impl_reset[i];
		end
		chk("levels reset", {15{3'h4}}, levels_q);
		// all ones and all zeros with full strobes first, then random patterns and lanes
		for (int k = 0; k < 30; k++)
			for (int i = 0; i < prio_pkg::num_regs; i++)
			begin
				d = (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h0000_0000 : $random(seed);
				st = (k < 2) ? 4'hF : 4'($random(seed));
				pstrb <= st;
				apb(1'b1, 12'(4 * i), d);
				shadow[i] = lane_exp(shadow[i], st, d[15:0], prio_pkg::impl_mask[i]);
				apb(1'b0, 12'(4 * i), 32'h0000_0000);
				chk("field", {16'h0000, shadow[i]}, rd);
				chk("levels", lv_exp(), levels_q);
			end
		pstrb <= 4'hF;
		apb(1'b1, prio_pkg::adc_pair6_7_priority_off, 32'h0000_0061);
		repeat (2) @(posedge clk);
		chk("pair6_7", 32'h0000_0031, {26'h000_0000, levels_q.adc_pair7_level, levels_q.adc_pair6_level});
		hold <= 1'b0;
		repeat (30) @(posedge clk);
		hold <= 1'b1;
		repeat (4) @(posedge clk);
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq_q});
		apb(1'b1, prio_pkg::pending_vector_status_off, 32'hFFFF_FFFF);
		chk("ro write", 32'h0000_0000, {31'h0000_0000, err});
		apb(1'b0, prio_pkg::pending_vector_status_off, 32'h0000_0000);
		chk("status", stat_exp(lvl, vec), rd);
		apb(1'b0, prio_pkg::irq_status_off, 32'h0000_0000);
		chk("events", 32'h0000_0003, rd);
		apb(1'b1, prio_pkg::irq_mask_off, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk("irq on", 32'h0000_0001, {31'h0000_0000, irq_q});
		apb(1'b1, prio_pkg::irq_status_off, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk("irq off", 32'h0000_0000, {31'h0000_0000, irq_q});
		apb(1'b0, 12'h024, 32'h0000_0000);
		chk("unmapped", 32'h0000_0001, {31'h0000_0000, err});
		apb(1'b0, 12'h005, 32'h0000_0000);
		chk("misaligned", 32'h0000_0001, {31'h0000_0000, err});
		chk("misaligned data", 32'h0000_0000, rd);
		close_out;
	end
endmodule
`default_nettype wire
